// [dv/canopen_error_control_test.sv]
// Self-checking bench for the CANopen error control block
`timescale 1ns/100ps
module canopen_error_control_test;
  import cec_pkg::*;
  localparam int MSC = 10;
  logic        core_clk = 1'b0, srst = 1'b1, ce = 1'b1;
  logic        reset_comm = 1'b0, fault_mode = 1'b0, slow = 1'b0;
  logic        od_req = 1'b0, od_we = 1'b0, exp_pre = 1'b0, tog = 1'b0;
  logic [15:0] od_index = 16'h0;
  logic [7:0]  od_sub = 8'h0;
  logic [31:0] od_wdata = 32'h0;
  logic        od_ack, od_err, tx_valid, tx_ready, rx_valid, rx_rtr;
  logic        force_preop, comm_offline_alarm, comm_offline_fault;
  logic        guard_armed, rd;
  logic [6:0]  node_id;
  logic [10:0] rx_id, tx_id, cob;
  logic [7:0]  tx_data;
  logic [31:0] od_rdata;
  logic [33:0] oe;
  logic [18:0] q_tx[$];
  logic [33:0] q_od[$];
  cec_nmt_t    node_state = NMT_PREOP;
  int          err_count = 0, checked = 0, k, g, seed = 32'hF936;

  assign cob = ERRCTL_COB_BASE + {4'h0, node_id};
  always #5 core_clk = ~core_clk;

  cec_errctl #(.MS_CYCLES(MSC)) DUT (
    .core_clk, .srst, .ce, .node_id, .node_state, .reset_comm, .fault_mode,
    .rx_valid, .rx_id, .rx_rtr, .od_req, .od_we, .od_index, .od_sub,
    .od_wdata, .od_ack, .od_err, .od_rdata, .tx_valid, .tx_id, .tx_data,
    .tx_ready, .force_preop, .comm_offline_alarm, .comm_offline_fault,
    .guard_armed
  );
  cec_master_model m (
    .core_clk, .slow, .tx_valid, .rx_valid, .rx_id, .rx_rtr, .tx_ready
  );

  task automatic chk(input string n, input logic [39:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run;
    chk("leftover", 40'h0, 40'(q_od.size() + q_tx.size()));
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Writes and refused reads note only the error flag; good reads note the data too
  task automatic od(input logic w, input logic [15:0] i,
                    input logic [7:0] s, input logic [31:0] d, input logic e);
    q_od.push_back({w, e, d});
    @(posedge core_clk);
    od_req <= 1'b1;
    od_we <= w;
    od_index <= i;
    od_sub <= s;
    od_wdata <= d;
    @(posedge core_clk);
    od_req <= 1'b0;
    od_wdata <= $random(seed);
  endtask

  task automatic drain;
    for (k = 0; k < 300 && q_tx.size() + q_od.size() != 0; k++)
      @(posedge core_clk);
    if (q_tx.size() + q_od.size() != 0)
      complete_run;
  endtask

  function automatic logic [6:0] code(input cec_nmt_t s);
    return s == NMT_STOPPED ? 7'h04 : s == NMT_OPER ? 7'h05 : 7'h7F;
  endfunction

  task automatic poll(input cec_nmt_t s);
    node_state <= s;
    q_tx.push_back({cob, tog, code(s)});
    tog = ~tog;
    m.send(cob, 1'b1);
    drain;
  endtask

  // Gap counted from the edge that took the last frame
  task automatic expire(input int lo, hi);
    exp_pre = 1'b1;
    for (k = 0; k < 200 && force_preop !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    g = int'(($time - m.t_last) / 10);
    chk("expiry_gap", 40'h1, {39'h0, g >= lo && g <= hi});
    if (k == 200)
      complete_run;
    cyc(1);
    exp_pre = 1'b0;
  endtask

  always @(negedge core_clk) begin
    if (od_ack === 1'b1) begin
      if (q_od.size() == 0)
        chk("od_ack", 40'h0, 40'h1);
      else begin
        oe = q_od.pop_front();
        rd = !oe[33] && !oe[32];
        chk("od_resp", {7'h0, oe[32], rd ? oe[31:0] : 32'h0},
            {7'h0, od_err, rd ? od_rdata : 32'h0});
      end
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (q_tx.size() == 0)
        chk("tx_frame", 40'h0, 40'h1);
      else
        chk("tx_frame", {21'h0, q_tx.pop_front()},
            {21'h0, tx_id, tx_data});
    end
    if (force_preop === 1'b1 && !exp_pre)
      chk("force_preop", 40'h0, 40'h1);
  end

  initial begin
    node_id = 7'($random(seed));
    cyc(2);
    srst <= 1'b0;
    od(0, OD_HB_CONS, 8'h00, 32'h2, 0);
    od(1, OD_HB_CONS, 8'h00, 32'h3, 1);
    od(0, OD_GUARD_TIME, 8'h00, 32'h0, 0);
    od(0, OD_HB_PROD, 8'h00, 32'h0, 0);
    od(0, 16'h1018, 8'h00, 32'h0, 1);
    od(1, OD_GUARD_TIME, 8'h00, 32'h1, 1);
    od(1, OD_GUARD_TIME, 8'h00, 32'h2, 0);
    od(1, OD_LIFE_FACTOR, 8'h00, 32'h3, 0);
    od(0, OD_LIFE_FACTOR, 8'h00, 32'h3, 0);
    cyc(80);
    chk("guard_armed", 40'h0, {39'h0, guard_armed});
    for (int i = 0; i < 3; i++) begin
      poll(cec_nmt_t'(i));
      cyc(25);
    end
    chk("guard_armed", 40'h1, {39'h0, guard_armed});
    // Frozen clock enable must hold the guard window open
    ce <= 1'b0;
    cyc(100);
    chk("guard_armed", 40'h1, {39'h0, guard_armed});
    ce <= 1'b1;
    od(1, OD_HB_PROD, 8'h00, 32'h5, 1);
    poll(NMT_STOPPED);
    expire((2 * 3 - 1) * MSC, 2 * 3 * MSC + 3);
    chk("alarm", 40'h1, {39'h0, comm_offline_alarm});
    chk("guard_armed", 40'h0, {39'h0, guard_armed});
    od(1, OD_LIFE_FACTOR, 8'h00, 32'h3, 0);
    drain;
    chk("alarm", 40'h0, {39'h0, comm_offline_alarm});
    od(1, OD_GUARD_TIME, 8'h00, 32'h0, 0);
    od(1, OD_HB_CONS, 8'h02, 32'h1, 1);
    od(1, OD_HB_CONS, 8'h01, 32'h0025_0003, 0);
    od(0, OD_HB_CONS, 8'h01, 32'h0025_0003, 0);
    fault_mode <= 1'b1;
    cyc(80);
    m.send(ERRCTL_COB_BASE + 11'h025, 1'b0);
    expire(2 * MSC, 3 * MSC + 3);
    chk("fault", 40'h1, {39'h0, comm_offline_fault});
    reset_comm <= 1'b1;
    cyc(1);
    reset_comm <= 1'b0;
    tog = 1'b0;
    od(0, OD_HB_CONS, 8'h01, 32'h0, 0);
    od(0, OD_LIFE_FACTOR, 8'h00, 32'h0, 0);
    od(1, OD_GUARD_TIME, 8'h00, 32'h2, 0);
    poll(NMT_PREOP);
    cyc(80);
    chk("guard_armed", 40'h0, {39'h0, guard_armed});
    slow <= 1'b1;
    node_state <= NMT_OPER;
    repeat (3) q_tx.push_back({cob, 8'h05});
    od(1, OD_HB_PROD, 8'h00, 32'h2, 0);
    drain;
    od(1, OD_HB_PROD, 8'h00, 32'h0, 0);
    cyc(60);
    complete_run;
  end
endmodule

// [dv/cec_errctl_assertions.sv]
// Assertion checker for the CANopen error control block
`timescale 1ns/100ps
module cec_errctl_chk
  import cec_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic [6:0]  node_id,
  input wire logic        reset_comm,
  input wire logic        fault_mode,
  input wire logic        rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic        rx_rtr,
  input wire logic        od_req,
  input wire logic        od_we,
  input wire logic [15:0] od_index,
  input wire logic [7:0]  od_sub,
  input wire logic [31:0] od_wdata,
  input wire logic        od_ack,
  input wire logic        od_err,
  input wire logic [31:0] od_rdata,
  input wire logic        tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic        force_preop,
  input wire logic        comm_offline_alarm,
  input wire logic        comm_offline_fault,
  input wire logic        guard_armed
);
  logic        poll;
  logic [31:0] gap_q;

  assign poll = rx_valid && rx_rtr && ce &&
                rx_id == ERRCTL_COB_BASE + {4'h0, node_id};

  // Cycles since the last guard request, saturating
  always_ff @(posedge core_clk) begin
    if (srst || poll)
      gap_q <= 32'h0;
    else if (ce && gap_q != 32'hFFFF_FFFF)
      gap_q <= gap_q + 32'h1;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  property p_sub0;
    od_req && ce && od_index == OD_HB_CONS && od_sub == OD_SUB0
      |=> od_ack && od_err == $past(od_we) && (od_err || od_rdata == 32'h2);
  endproperty
  a_sub0: assert property (p_sub0)
    else $error("entry count access wrong");

  property p_min_time;
    od_req && ce && od_we && od_index == OD_GUARD_TIME && od_wdata == 32'h1
      |=> od_ack && od_err;
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("short guard time taken");

  property p_one_service;
    od_req && ce && od_we && od_index == OD_HB_PROD && od_wdata[7:0] != 8'h0
      && guard_armed |=> od_ack && od_err;
  endproperty
  a_one_service: assert property (p_one_service)
    else $error("heartbeat enabled beside guarding");

  property p_frame_id;
    tx_valid |-> tx_id == ERRCTL_COB_BASE + {4'h0, node_id};
  endproperty
  a_frame_id: assert property (p_frame_id)
    else $error("frame id wrong");

  // Answer loads two cycles on unless reset communication cuts in
  property p_answer;
    poll && !tx_valid && !reset_comm |=> reset_comm or ##1 tx_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("guard answer missing");

  property p_alarm;
    force_preop && !fault_mode |-> ##[0:1] comm_offline_alarm;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm not raised");

  property p_fault;
    force_preop && fault_mode |-> ##[0:1] comm_offline_fault;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault not raised");

  // Guarding on excludes consumers, so this expiry is the guard's
  property p_guard_min;
    force_preop && $past(guard_armed) |-> gap_q >= MS_CYCLES;
  endproperty
  a_guard_min: assert property (p_guard_min)
    else $error("guard expiry too early");

  c_poll: cover property (poll);
  c_expiry: cover property (force_preop);
  c_refused: cover property (od_ack && od_err);
endmodule

bind cec_errctl cec_errctl_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .core_clk, .srst, .ce, .node_id, .reset_comm, .fault_mode, .rx_valid,
  .rx_id, .rx_rtr, .od_req, .od_we, .od_index, .od_sub, .od_wdata, .od_ack,
  .od_err, .od_rdata, .tx_valid, .tx_id, .force_preop, .comm_offline_alarm,
  .comm_offline_fault, .guard_armed
);

// [dv/cec_master_model.sv]
// Network master stand-in: sends frames, takes node frames
`timescale 1ns/100ps
module cec_master_model (
  input  wire logic        core_clk,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  output logic             rx_valid,
  output logic [10:0]      rx_id,
  output logic             rx_rtr,
  output logic             tx_ready
);
  logic [1:0] div_q = 2'h0;
  time        t_last = 0;

  initial begin
    rx_valid = 1'b0;
    rx_id = 11'h0;
    rx_rtr = 1'b0;
    tx_ready = 1'b0;
  end

  // Slow mode takes a node frame only every fourth cycle
  always @(posedge core_clk) begin
    div_q <= div_q + 2'h1;
    tx_ready <= !slow || div_q == 2'h3;
  end

  // One frame; a guard poll is remote with no data bytes
  task automatic send(input logic [10:0] id, input logic rtr);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_rtr <= rtr;
    @(posedge core_clk);
    t_last = $time;
    rx_valid <= 1'b0;
    // Released lines show inverted values, never the stale frame
    rx_id <= ~id;
    rx_rtr <= ~rtr;
  endtask
endmodule

// [verilog/cec_errctl.sv]
// CANopen node guarding and heartbeat error control
`timescale 1ns/100ps
module cec_errctl
  import cec_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [6:0]  node_id,
  input  cec_nmt_t         node_state,
  input  wire logic        reset_comm,
  input  wire logic        fault_mode,
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic        rx_rtr,
  input  wire logic        od_req,
  input  wire logic        od_we,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_sub,
  input  wire logic [31:0] od_wdata,
  output logic             od_ack,
  output logic             od_err,
  output logic [31:0]      od_rdata,
  output logic             tx_valid,
  output logic [10:0]      tx_id,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic             force_preop,
  output logic             comm_offline_alarm,
  output logic             comm_offline_fault,
  output logic             guard_armed
);

  // Object storage
  logic [31:0] guard_q;
  logic [7:0]  factor_q;
  logic [31:0] cons_q [CONS_ENTRIES];
  logic [7:0]  prod_q;

  // Bus answer registers
  logic        od_ack_q;
  logic        od_err_q;
  logic [31:0] od_rdata_q;

  // Supervision state
  logic                    guard_armed_q;
  logic [CONS_ENTRIES-1:0] cons_armed_q;
  logic                    alarm_q;
  logic                    fault_q;
  logic                    preop_q;

  // Transmit path
  logic        tx_valid_q;
  logic [10:0] tx_id_q;
  logic [7:0]  tx_data_q;
  logic        toggle_q;
  logic        guard_pend_q;
  logic        hb_pend_q;

  // Millisecond prescaler
  logic [31:0] tick_cnt_q;
  logic        tick_q;

  // Decoded conditions
  logic                    obj_rst;
  logic                    guard_en;
  logic                    prod_en;
  logic [CONS_ENTRIES-1:0] cons_en;
  logic                    hb_any;
  logic [10:0]             own_cob;
  logic                    guard_req;
  logic [CONS_ENTRIES-1:0] hb_seen;
  logic                    guard_exp;
  logic [CONS_ENTRIES-1:0] cons_exp;
  logic                    prod_exp;
  logic                    ind_set;
  logic                    ind_clr;
  logic [6:0]              st_code;
  logic                    load_g;
  logic                    load_h;

  // Object access decode
  logic        od_hit;
  logic        od_ro;
  logic        wr_bad;
  logic        wr_ok;
  logic        wr_enables;
  logic [31:0] rd_val;
  logic        csel;

  // Timer bundles
  logic               t_restart [NUM_TIMERS];
  logic               t_run     [NUM_TIMERS];
  logic [TIMER_W-1:0] t_limit   [NUM_TIMERS];
  logic               t_exp     [NUM_TIMERS];

  // Communication objects are volatile; both resets restore defaults
  assign obj_rst = srst || reset_comm;

  assign guard_en = (guard_q != 32'h0) && (factor_q != 8'h0);
  assign prod_en  = (prod_q != 8'h0);
  assign hb_any   = prod_en || (|cons_en);
  assign own_cob  = ERRCTL_COB_BASE + {4'h0, node_id};

  // Master's poll carries no data; only id and remote flag are checked
  assign guard_req = rx_valid && rx_rtr && (rx_id == own_cob);

  always_comb begin
    case (node_state)
      NMT_STOPPED: st_code = ST_STOPPED;
      NMT_OPER:    st_code = ST_OPER;
      NMT_PREOP:   st_code = ST_PREOP;
      default:     st_code = ST_PREOP;
    endcase
  end

  // Consumer entry decode, node field bit 23 unused by 7-bit ids
  genvar i;
  generate
    for (i = 0; i < CONS_ENTRIES; i++) begin : g_cons
      assign cons_en[i] = (cons_q[i][CONS_TIME_MSB:0] != 16'h0);
      assign hb_seen[i] = rx_valid && !rx_rtr &&
        (rx_id == ERRCTL_COB_BASE +
         {4'h0, cons_q[i][CONS_NODE_MSB:CONS_NODE_LSB]});
      assign cons_exp[i] = t_exp[T_CONS0 + i];
      assign t_restart[T_CONS0 + i] = hb_seen[i];
      assign t_run[T_CONS0 + i]     = cons_en[i] && cons_armed_q[i];
      assign t_limit[T_CONS0 + i]   =
        {24'h0, cons_q[i][CONS_TIME_MSB:0]};

      always_ff @(posedge core_clk) begin
        if (obj_rst) begin
          cons_armed_q[i] <= 1'b0;
        end else if (ce) begin
          if (hb_seen[i] && cons_en[i]) begin
            cons_armed_q[i] <= 1'b1;
          end else if (cons_exp[i] || !cons_en[i]) begin
            cons_armed_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Guard timer: window is guard time times factor
  assign t_restart[T_GUARD] = guard_req;
  assign t_run[T_GUARD]     = guard_en && guard_armed_q;
  assign t_limit[T_GUARD]   = TIMER_W'(guard_q) * TIMER_W'(factor_q);
  assign guard_exp          = t_exp[T_GUARD];

  // Producer timer restarts itself on each expiry
  assign t_restart[T_PROD] = 1'b0;
  assign t_run[T_PROD]     = prod_en;
  assign t_limit[T_PROD]   = {32'h0, prod_q};
  assign prod_exp          = t_exp[T_PROD];

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      cec_timer_if #(.W(TIMER_W)) tif (.core_clk(core_clk));
      assign tif.srst    = obj_rst;
      assign tif.ce      = ce;
      assign tif.tick    = tick_q;
      assign tif.restart = t_restart[g];
      assign tif.run     = t_run[g];
      assign tif.limit   = t_limit[g];
      assign t_exp[g]    = tif.expired;
      cec_ms_timer #(.W(TIMER_W)) u_tmr (.t(tif.tmr));
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (ce) begin
      tick_q <= (tick_cnt_q == 32'(MS_CYCLES - 1));
      if (tick_cnt_q == 32'(MS_CYCLES - 1)) begin
        tick_cnt_q <= 32'h0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  // No state gating: supervision runs in stopped too
  always_ff @(posedge core_clk) begin
    if (obj_rst) begin
      guard_armed_q <= 1'b0;
    end else if (ce) begin
      if (guard_req && guard_en) begin
        guard_armed_q <= 1'b1;
      end else if (guard_exp || !guard_en) begin
        guard_armed_q <= 1'b0;
      end
    end
  end

  assign ind_set = guard_exp || (|cons_exp);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      preop_q <= 1'b0;
    end else if (ce) begin
      preop_q <= ind_set;
    end
  end

  // Set wins over the re-enable clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alarm_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (ce) begin
      if (ind_set && !fault_mode) begin
        alarm_q <= 1'b1;
      end else if (ind_clr) begin
        alarm_q <= 1'b0;
      end
      if (ind_set && fault_mode) begin
        fault_q <= 1'b1;
      end else if (ind_clr) begin
        fault_q <= 1'b0;
      end
    end
  end

  // Object dictionary decode and write checks
  always_comb begin
    od_hit     = 1'b0;
    od_ro      = 1'b0;
    wr_bad     = 1'b0;
    wr_enables = 1'b0;
    rd_val     = 32'h0;
    csel       = od_sub[0] ? 1'b0 : 1'b1;
    case (od_index)
      OD_GUARD_TIME: begin
        if (od_sub == OD_SUB0) begin
          od_hit     = 1'b1;
          rd_val     = guard_q;
          wr_enables = (od_wdata != 32'h0) && (factor_q != 8'h0);
          wr_bad = ((od_wdata != 32'h0) &&
                    (od_wdata < MIN_TIME_MS)) ||
                   (wr_enables && hb_any);
        end
      end
      OD_LIFE_FACTOR: begin
        if (od_sub == OD_SUB0) begin
          od_hit     = 1'b1;
          rd_val     = {24'h0, factor_q};
          wr_enables = (od_wdata[7:0] != 8'h0) && (guard_q != 32'h0);
          wr_bad     = wr_enables && hb_any;
        end
      end
      OD_HB_CONS: begin
        if (od_sub == OD_SUB0) begin
          od_hit = 1'b1;
          od_ro  = 1'b1;
          rd_val = {24'h0, CONS_COUNT_RST};
        end else if (od_sub <= CONS_COUNT_RST) begin
          od_hit     = 1'b1;
          rd_val     = cons_q[csel];
          wr_enables = (od_wdata[CONS_TIME_MSB:0] != 16'h0);
          wr_bad = (wr_enables &&
                    ({16'h0, od_wdata[CONS_TIME_MSB:0]} <
                     MIN_TIME_MS)) ||
                   (wr_enables && guard_en);
        end
      end
      OD_HB_PROD: begin
        if (od_sub == OD_SUB0) begin
          od_hit     = 1'b1;
          rd_val     = {24'h0, prod_q};
          wr_enables = (od_wdata[7:0] != 8'h0);
          wr_bad = (wr_enables &&
                    ({24'h0, od_wdata[7:0]} < MIN_TIME_MS)) ||
                   (wr_enables && guard_en);
        end
      end
      default: begin
        od_hit = 1'b0;
      end
    endcase
  end

  assign wr_ok   = od_req && od_we && od_hit && !od_ro && !wr_bad;
  assign ind_clr = wr_ok && wr_enables;

  always_ff @(posedge core_clk) begin
    if (obj_rst) begin
      guard_q  <= GUARD_RST;
      factor_q <= FACTOR_RST;
      prod_q   <= PROD_RST;
      for (int k = 0; k < CONS_ENTRIES; k++) begin
        cons_q[k] <= CONS_RST;
      end
    end else if (ce && wr_ok) begin
      case (od_index)
        OD_GUARD_TIME:  guard_q  <= od_wdata;
        OD_LIFE_FACTOR: factor_q <= od_wdata[7:0];
        OD_HB_CONS:     cons_q[csel] <= od_wdata;
        OD_HB_PROD:     prod_q   <= od_wdata[7:0];
        default:        guard_q  <= guard_q;
      endcase
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      od_ack_q   <= 1'b0;
      od_err_q   <= 1'b0;
      od_rdata_q <= 32'h0;
    end else if (ce) begin
      od_ack_q <= od_req;
      od_err_q <= od_req && (!od_hit || (od_we && (od_ro || wr_bad)));
      if (od_req && !od_we && od_hit) begin
        od_rdata_q <= rd_val;
      end
    end
  end

  // Transmit: guarding answer ahead of heartbeat
  assign load_g = !tx_valid_q && guard_pend_q;
  assign load_h = !tx_valid_q && !guard_pend_q && hb_pend_q;

  always_ff @(posedge core_clk) begin
    if (obj_rst) begin
      guard_pend_q <= 1'b0;
      hb_pend_q    <= 1'b0;
    end else if (ce) begin
      guard_pend_q <= (guard_pend_q && !load_g) || guard_req;
      hb_pend_q    <= (hb_pend_q && !load_h) || prod_exp;
    end
  end

  always_ff @(posedge core_clk) begin
    if (obj_rst) begin
      toggle_q <= 1'b0;
    end else if (ce && load_g) begin
      toggle_q <= !toggle_q;
    end
  end

  // Frame held until the controller takes it
  always_ff @(posedge core_clk) begin
    if (obj_rst) begin
      tx_valid_q <= 1'b0;
      tx_id_q    <= 11'h0;
      tx_data_q  <= 8'h0;
    end else if (ce) begin
      if (tx_valid_q && tx_ready) begin
        tx_valid_q <= 1'b0;
      end else if (load_g || load_h) begin
        tx_valid_q <= 1'b1;
        tx_id_q    <= own_cob;
        if (load_g) begin
          tx_data_q <= {toggle_q, st_code};
        end else begin
          tx_data_q <= {1'b0, st_code};
        end
      end
    end
  end

  assign od_ack             = od_ack_q;
  assign od_err             = od_err_q;
  assign od_rdata           = od_rdata_q;
  assign tx_valid           = tx_valid_q;
  assign tx_id              = tx_id_q;
  assign tx_data            = tx_data_q;
  assign force_preop        = preop_q;
  assign comm_offline_alarm = alarm_q;
  assign comm_offline_fault = fault_q;
  assign guard_armed        = guard_armed_q;

endmodule

// [verilog/cec_ms_timer.sv]
// Millisecond watchdog with one-cycle expiry pulse
`timescale 1ns/100ps
module cec_ms_timer #(
  parameter int W = 40
) (
  cec_timer_if.tmr t
);

  logic [W-1:0] cnt_q;
  logic         exp_q;

  // First tick may come early by up to one ms; cheap shared prescaler
  always_ff @(posedge t.core_clk) begin
    if (t.srst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (t.ce) begin
      exp_q <= 1'b0;
      if (t.restart || !t.run) begin
        cnt_q <= '0;
      end else if (t.tick) begin
        if (cnt_q + 1'b1 >= t.limit) begin
          cnt_q <= '0;
          exp_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign t.expired = exp_q;

endmodule

// [verilog/cec_pkg.sv]
// Constants and types for the CANopen error control block
// What this block does
// - Answer one byte: state bits, toggle bit7
// - State codes: stopped 4, operational 5, preop 127
// - Guard error after guard time times factor
// - Zero guard time or factor disables guarding
// - Guard timing starts at first request
// - Guard error forces preop and offline indication
// - Error control stays active when stopped
// - Re-enabling a service clears error indication
// - Programmed times below 2 ms refused
// - Heartbeat and guarding never both enabled
// - Two consumer entries, count reads 2
// - Entry: reserved byte, node byte, 16-bit time
// - Consumer time in ms, zero disables entry
// - Consumer monitors after first producer heartbeat
// - Missed heartbeat forces preop and offline indication
// - Nonzero producer period sends periodic heartbeat
// - Heartbeat 700h+node, bit7 zero, state bits
// - Objects return to defaults after reset
// - Reset communication reinitialises objects, supervision, timers, toggle and transmit path; not indication
package cec_pkg;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES_DFLT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [10:0] ERRCTL_COB_BASE = 11'h700;

  localparam logic [6:0] ST_STOPPED = 7'h04;
  localparam logic [6:0] ST_OPER    = 7'h05;
  localparam logic [6:0] ST_PREOP   = 7'h7F;
  localparam int         TOGGLE_BIT = 7;

  localparam logic [15:0] OD_GUARD_TIME  = 16'h100C;
  localparam logic [15:0] OD_LIFE_FACTOR = 16'h100D;
  localparam logic [15:0] OD_HB_CONS     = 16'h1016;
  localparam logic [15:0] OD_HB_PROD     = 16'h1017;
  localparam logic [7:0]  OD_SUB0        = 8'h00;

  localparam int         CONS_ENTRIES   = 2;
  localparam logic [7:0] CONS_COUNT_RST = 8'h02;
  localparam int         CONS_TIME_MSB  = 15;
  localparam int         CONS_NODE_LSB  = 16;
  localparam int         CONS_NODE_MSB  = 22;

  localparam logic [31:0] GUARD_RST  = 32'h0;
  localparam logic [7:0]  FACTOR_RST = 8'h0;
  localparam logic [31:0] CONS_RST   = 32'h0;
  localparam logic [7:0]  PROD_RST   = 8'h0;

  localparam logic [31:0] MIN_TIME_MS = 32'h2;

  localparam int TIMER_W    = 40;
  localparam int NUM_TIMERS = 4;
  localparam int T_GUARD    = 0;
  localparam int T_CONS0    = 1;
  localparam int T_PROD     = 3;

  typedef enum logic [1:0] {
    NMT_STOPPED,
    NMT_OPER,
    NMT_PREOP
  } cec_nmt_t;

endpackage

// [verilog/cec_timer_if.sv]
// Millisecond timer control bundle
`timescale 1ns/100ps
interface cec_timer_if #(parameter int W = 40) (input wire logic core_clk);
  logic         srst;
  logic         ce;
  logic         tick;
  logic         restart;
  logic         run;
  logic [W-1:0] limit;
  logic         expired;
  modport ctl (output srst, ce, tick, restart, run, limit, input expired);
  modport tmr (input core_clk, srst, ce, tick, restart, run, limit,
               output expired);
endinterface
